// ---- stm0_serial_consts.svh ----
// register map, field positions, reset values and timing counts of the serial line port
`ifndef STM0_SERIAL_CONSTS_SVH
`define STM0_SERIAL_CONSTS_SVH

`define ADDR_W          4
`define DATA_W          16

`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_MASK        4'h2
`define REG_RX          4'h3
`define REG_TX          4'h4

`define CTRL_W          4
`define CTRL_SERIAL_EN  0
`define CTRL_RX_FALL    1
`define CTRL_TX_FALL    2
`define CTRL_LOOP       3
`define CTRL_RST        4'h0

`define EV_W            5
`define EV_RX_FRAME     0
`define EV_RX_BYTE      1
`define EV_LOS          2
`define EV_MISALIGN     3
`define EV_TX_FRAME     4
`define MASK_RST        5'h00
`define TX_BYTE_RST     8'h00

`define RX_LOS_BIT      8
`define RX_LOCK_BIT     9

`define FRAME_BITS      6480
`define IDX_W           13
`define LAST_IDX        13'h194F

`define SYS_CLK_NS      40
`define LOCAL_CLK_NS    160
`define LOCAL_HALF      (`LOCAL_CLK_NS / (2 * `SYS_CLK_NS))

`endif

// ---- stm0_serial_pkg.sv ----
// types shared by the serial line port modules
package stm0_serial_pkg;
    `include "stm0_serial_consts.svh"

    typedef logic [`IDX_W-1:0]  bit_idx_t;
    typedef logic [`EV_W-1:0]   event_t;
    typedef logic [`CTRL_W-1:0] ctrl_t;
    typedef enum logic {RX_HUNT, RX_LOCKED} rx_state_t;
endpackage

// ---- line_edge_finder.sv ----
// two-flop synchroniser for the receive pins, with edge detection on bit 0
`timescale 1ns/1ps
module line_edge_finder (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_pins,
    output logic      [3:0] o_level,
    output logic            o_rise,
    output logic            o_fall
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic       prev;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = i_pins;
        st_nxt.s2   = st_r.s1;
        st_nxt.prev = st_r.s2[0];
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.s2;
    assign o_rise  = st_r.s2[0] & ~st_r.prev;
    assign o_fall  = ~st_r.s2[0] & st_r.prev;
endmodule

// ---- frame_bit_counter.sv ----
// position of the next bit within an STM-0 frame
`timescale 1ns/1ps
module frame_bit_counter
    import stm0_serial_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_clear,
    input  wire logic i_step,
    input  wire logic i_align,
    output bit_idx_t  o_idx
);
    typedef struct packed {
        bit_idx_t idx;
    } cnt_st_t;

    cnt_st_t st_r;
    cnt_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (i_clear) begin
            st_nxt.idx = '0;
        end else if (i_step && i_align) begin
            // the aligning bit itself is bit 0
            st_nxt.idx = bit_idx_t'(1);
        end else if (i_step) begin
            st_nxt.idx = (st_r.idx == `LAST_IDX) ? '0 : st_r.idx + bit_idx_t'(1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_idx = st_r.idx;
endmodule

// ---- stm0_serial_line_port.sv ----
// bit-serial STM-0 line port: receive framer, transmit serialiser, registers
//
// Notes on behaviour
// RULE1 - a control bit picks the serial port over the parallel bus, and the serial pins idle otherwise.
// RULE2 - receive data is sampled on the rising or falling receive clock edge, as configured.
// RULE3 - the far end marks each frame's first bit with the receive frame pulse, which sets alignment.
// RULE4 - the loss-of-signal input from the line interface unit is taken as line loss of signal.
// RULE5 - the transmit clock copies the receive line clock in loop timing, else the master clock.
// RULE6 - transmit data is launched on the configured edge of our own transmit clock.
// RULE7 - the transmit frame pulse rises with the first bit of every frame sent.
// RULE8 - each frame pulse lasts exactly one serial bit, the first, and is low for all others.
`timescale 1ns/1ps
module stm0_serial_line_port
    import stm0_serial_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_rx_serial_line_clock,
    input  wire logic              i_rx_serial_line_data,
    input  wire logic              i_rx_serial_frame_pulse,
    input  wire logic              i_rx_serial_signal_loss,
    input  wire logic [`ADDR_W-1:0] i_addr,
    input  wire logic [`DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [`DATA_W-1:0] o_rdata,
    output logic                   o_irq,
    output logic                   o_serial_mode,
    output logic                   o_tx_serial_line_clock,
    output logic                   o_tx_serial_line_data,
    output logic                   o_tx_serial_frame_pulse
);
    typedef struct packed {
        ctrl_t              ctrl;
        event_t             status;
        event_t             mask;
        logic [7:0]         tx_byte;
        logic [7:0]         rx_byte;
        logic [7:0]         rx_shift;
        logic [7:0]         tx_shift;
        logic               rx_fp_prev;
        logic               los_prev;
        rx_state_t          rx_state;
        logic [1:0]         div_cnt;
        logic               local_clk;
        logic               tx_clk;
        logic               tx_data;
        logic               tx_fp;
        logic               irq;
        logic [`DATA_W-1:0] rdata;
    } port_st_t;

    port_st_t st_r;
    port_st_t st_nxt;

    logic [3:0] lvl;
    logic       clk_rise;
    logic       clk_fall;
    bit_idx_t   rx_idx;
    bit_idx_t   tx_idx;

    logic       serial_en;
    logic       rx_edge;
    logic       rx_fp_first;
    logic       tx_clk_val;
    logic       tx_launch;
    event_t     events;
    event_t     clr;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and frame position counters

    // data, frame and loss ride the same two flops as the clock, so they stay in step
    line_edge_finder u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pins    ({i_rx_serial_signal_loss, i_rx_serial_frame_pulse,
                     i_rx_serial_line_data, i_rx_serial_line_clock}),
        .o_level   (lvl),
        .o_rise    (clk_rise),
        .o_fall    (clk_fall)
    );

    frame_bit_counter u_rx_cnt (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_clear   (~serial_en),
        .i_step    (rx_edge),
        .i_align   (rx_fp_first),
        .o_idx     (rx_idx)
    );

    frame_bit_counter u_tx_cnt (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_clear   (~serial_en),
        .i_step    (tx_launch),
        .i_align   (1'b0),
        .o_idx     (tx_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_nxt = st_r;
        events = '0;
        clr    = '0;
        // RULE1 - serial select gate
        serial_en = st_r.ctrl[`CTRL_SERIAL_EN];

        // RULE2 - pick sampling edge
        rx_edge = serial_en && (st_r.ctrl[`CTRL_RX_FALL] ? clk_fall : clk_rise);
        // RULE8 - only the first bit of a pulse counts
        rx_fp_first = rx_edge && lvl[2] && !st_r.rx_fp_prev;

        if (rx_edge) begin
            st_nxt.rx_fp_prev = lvl[2];
            st_nxt.rx_shift   = {st_r.rx_shift[6:0], lvl[1]};
            if (st_r.rx_state == RX_LOCKED && !rx_fp_first && rx_idx[2:0] == 3'h7) begin
                st_nxt.rx_byte          = {st_r.rx_shift[6:0], lvl[1]};
                events[`EV_RX_BYTE] = 1'b1;
            end
        end

        // RULE3 - frame pulse locates the boundary
        if (rx_fp_first) begin
            st_nxt.rx_state          = RX_LOCKED;
            events[`EV_RX_FRAME] = 1'b1;
            events[`EV_MISALIGN] = (st_r.rx_state == RX_LOCKED) && (rx_idx != '0);
        end

        // RULE4 - loss of signal drops alignment
        st_nxt.los_prev = lvl[3];
        if (serial_en && lvl[3]) begin
            st_nxt.rx_state = RX_HUNT;
        end
        events[`EV_LOS] = serial_en && lvl[3] && !st_r.los_prev;
        if (!serial_en) begin
            st_nxt.rx_state   = RX_HUNT;
            st_nxt.rx_fp_prev = 1'b0;
        end

        // local master clock divider, free running
        if (st_r.div_cnt == 2'(`LOCAL_HALF - 1)) begin
            st_nxt.div_cnt   = '0;
            st_nxt.local_clk = ~st_r.local_clk;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + 2'h1;
        end

        // loop timing lags the pin by the synchroniser, three system cycles
        // RULE5 - transmit clock source
        tx_clk_val    = st_r.ctrl[`CTRL_LOOP] ? lvl[0] : st_r.local_clk;
        tx_clk_val    = serial_en & tx_clk_val;
        st_nxt.tx_clk = tx_clk_val;

        // RULE6 - data changes in the same cycle as the chosen clock edge
        tx_launch = serial_en && (st_r.ctrl[`CTRL_TX_FALL] ? (st_r.tx_clk && !tx_clk_val)
                                                          : (!st_r.tx_clk && tx_clk_val));
        if (tx_launch) begin
            if (tx_idx[2:0] == 3'h0) begin
                st_nxt.tx_data  = st_r.tx_byte[7];
                st_nxt.tx_shift = {st_r.tx_byte[6:0], 1'b0};
            end else begin
                st_nxt.tx_data  = st_r.tx_shift[7];
                st_nxt.tx_shift = {st_r.tx_shift[6:0], 1'b0};
            end
            // RULE7 - pulse with frame bit 0
            // RULE8 - low again at the next bit
            st_nxt.tx_fp         = (tx_idx == '0);
            events[`EV_TX_FRAME] = (tx_idx == '0);
        end
        if (!serial_en) begin
            st_nxt.tx_data = 1'b0;
            st_nxt.tx_fp   = 1'b0;
        end

        // register writes; a new event beats a clear in the same cycle
        if (i_wr) begin
            unique case (i_addr)
                `REG_CTRL:   st_nxt.ctrl    = i_wdata[`CTRL_W-1:0];
                `REG_STATUS: clr            = i_wdata[`EV_W-1:0];
                `REG_MASK:   st_nxt.mask    = i_wdata[`EV_W-1:0];
                `REG_TX:     st_nxt.tx_byte = i_wdata[7:0];
                default:     ;
            endcase
        end
        st_nxt.status = (st_r.status & ~clr) | events;
        st_nxt.irq    = |(st_nxt.status & st_nxt.mask);

        // read data valid only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                `REG_CTRL:   st_nxt.rdata[`CTRL_W-1:0] = st_r.ctrl;
                `REG_STATUS: st_nxt.rdata[`EV_W-1:0]   = st_r.status;
                `REG_MASK:   st_nxt.rdata[`EV_W-1:0]   = st_r.mask;
                `REG_RX: begin
                    st_nxt.rdata[7:0]          = st_r.rx_byte;
                    st_nxt.rdata[`RX_LOS_BIT]  = lvl[3];
                    st_nxt.rdata[`RX_LOCK_BIT] = (st_r.rx_state == RX_LOCKED);
                end
                `REG_TX:     st_nxt.rdata[7:0] = st_r.tx_byte;
                default:     st_nxt.rdata      = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_r         <= '0;
            st_r.ctrl    <= `CTRL_RST;
            st_r.mask    <= `MASK_RST;
            st_r.tx_byte <= `TX_BYTE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata                 = st_r.rdata;
    assign o_irq                   = st_r.irq;
    assign o_serial_mode           = st_r.ctrl[`CTRL_SERIAL_EN];
    assign o_tx_serial_line_clock  = st_r.tx_clk;
    assign o_tx_serial_line_data   = st_r.tx_data;
    assign o_tx_serial_frame_pulse = st_r.tx_fp;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    serial_off_quiet_a: assert property ( // RULE1
        !serial_en [*2] |-> !o_tx_serial_line_clock && !o_tx_serial_frame_pulse
                            && !o_tx_serial_line_data)
        else $error("serial pins active while serial port deselected");

    rx_sample_edge_a: assert property ( // RULE2
        rx_edge |=> st_r.rx_shift[0] == $past(lvl[1]))
        else $error("receive bit not taken at the chosen edge");

    rx_frame_align_a: assert property ( // RULE3
        rx_fp_first && !lvl[3] |=> rx_idx == bit_idx_t'(1) && st_r.rx_state == RX_LOCKED)
        else $error("receive frame pulse did not set alignment");

    los_accept_a: assert property ( // RULE4
        serial_en && lvl[3] |=> st_r.rx_state == RX_HUNT)
        else $error("loss of signal not honoured");

    los_event_a: assert property ( // RULE4
        serial_en && lvl[3] && !st_r.los_prev |=> st_r.status[`EV_LOS])
        else $error("loss of signal onset not flagged");

    tx_clk_source_a: assert property ( // RULE5
        serial_en && st_r.ctrl[`CTRL_LOOP] |=> o_tx_serial_line_clock == $past(lvl[0]))
        else $error("loop timing clock is not the receive clock");

    tx_launch_edge_a: assert property ( // RULE6
        serial_en && $changed(o_tx_serial_line_data) |-> $changed(o_tx_serial_line_clock)
            && (o_tx_serial_line_clock == !$past(st_r.ctrl[`CTRL_TX_FALL])))
        else $error("transmit data moved away from the chosen clock edge");

    tx_frame_first_a: assert property ( // RULE7
        tx_launch && tx_idx == '0 |=> o_tx_serial_frame_pulse && tx_idx == bit_idx_t'(1))
        else $error("transmit frame pulse missing at first bit");

    tx_pulse_width_a: assert property ( // RULE8
        tx_launch && tx_idx != '0 |=> !o_tx_serial_frame_pulse)
        else $error("transmit frame pulse longer than one bit");

    irq_gate_a: assert property (
        (st_r.status & st_r.mask) != '0 && !i_wr |-> o_irq)
        else $error("unmasked event not raising interrupt");

    tx_clk_local_a: assert property ( // RULE5
        serial_en && !st_r.ctrl[`CTRL_LOOP]
            |=> o_tx_serial_line_clock == $past(st_r.local_clk))
        else $error("local timing clock is not the master clock");

    rx_shift_hold_a: assert property ( // RULE2
        !rx_edge |=> $stable(st_r.rx_shift))
        else $error("receive shift moved without a sampling edge");

    rx_byte_locked_a: assert property ( // RULE3
        events[`EV_RX_BYTE] |-> st_r.rx_state == RX_LOCKED)
        else $error("receive byte delivered before frame alignment");

    rx_misalign_a: assert property ( // RULE3
        rx_fp_first && st_r.rx_state == RX_LOCKED && rx_idx != '0
            |=> st_r.status[`EV_MISALIGN])
        else $error("frame pulse off the expected boundary not flagged");

    status_sticky_a: assert property (
        events != '0 |=> (st_r.status & $past(events)) == $past(events))
        else $error("event lost against a status clear");

    rdata_one_cycle_a: assert property (
        !i_rd |=> o_rdata == '0)
        else $error("read data present without a read strobe");

    ////////////////////////////////////////////////////////////////////////
    // scenarios worth seeing in a run

    rx_lock_c:   cover property (rx_fp_first ##[1:300] events[`EV_RX_BYTE]);
    tx_frame_c:  cover property (events[`EV_TX_FRAME] && st_r.ctrl[`CTRL_LOOP]);
    misalign_c:  cover property (events[`EV_MISALIGN]);
    los_irq_c:   cover property (events[`EV_LOS] ##1 o_irq);
endmodule

// ---- line_unit_model.sv ----
// far-end line interface unit model driving the receive serial pins
`timescale 1ns/1ps
module line_unit_model (
    input  wire logic       i_run,
    input  wire logic       i_launch_rise,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_los,
    output logic            o_clk,
    output logic            o_data,
    output logic            o_frame,
    output logic            o_los
);
    int unsigned idx;
    logic [7:0]  sr;

    task automatic put_bit();
        if (idx % 8 == 0) begin
            sr = i_byte;
        end
        o_data  = sr[7];
        sr      = {sr[6:0], 1'b0};
        o_frame = (idx == 0);
        idx     = (idx + 1) % 6480;
    endtask

    initial begin
        o_clk   = 1'b0;
        o_data  = 1'b0;
        o_frame = 1'b0;
        idx     = 0;
        sr      = 8'h00;
        forever begin
            wait (i_run === 1'b1);
            // offset keeps link edges off the system clock edges
            #13;
            while (i_run === 1'b1) begin
                #160 o_clk = 1'b1;
                if (i_launch_rise) put_bit();
                #160 o_clk = 1'b0;
                if (!i_launch_rise) put_bit();
            end
            // released line: no stale value left showing
            o_data  = ~o_data;
            o_frame = 1'b0;
            idx     = 0;
        end
    end

    assign o_los = i_los;
endmodule

// ---- stm0_serial_line_port_tb_top.sv ----
// self-checking bench for the serial line port with a far-end model
`timescale 1ns/1ps
`include "stm0_serial_consts.svh"
module stm0_serial_line_port_tb_top;
    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic [3:0]  i_addr    = 4'h0;
    logic [15:0] i_wdata   = 16'h0000;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic        run       = 1'b0;
    logic        lrise     = 1'b0;
    logic [7:0]  pbyte     = 8'h00;
    logic        los       = 1'b0;
    logic        rxc, rxd, rxf, rxl, irq, smode, txc, txd, txf;
    logic [15:0] rv;
    logic [15:0] rv_bus;
    logic [7:0]  b;
    logic        d, fp;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    int          c0, c1, k;

    stm0_serial_line_port dut (
        .i_clk_sys              (i_clk_sys),
        .i_rst                  (i_rst),
        .i_rx_serial_line_clock (rxc),
        .i_rx_serial_line_data  (rxd),
        .i_rx_serial_frame_pulse(rxf),
        .i_rx_serial_signal_loss(rxl),
        .i_addr                 (i_addr),
        .i_wdata                (i_wdata),
        .i_wr                   (i_wr),
        .i_rd                   (i_rd),
        .o_rdata                (rv_bus),
        .o_irq                  (irq),
        .o_serial_mode          (smode),
        .o_tx_serial_line_clock (txc),
        .o_tx_serial_line_data  (txd),
        .o_tx_serial_frame_pulse(txf)
    );

    line_unit_model far (
        .i_run        (run),
        .i_launch_rise(lrise),
        .i_byte       (pbyte),
        .i_los        (los),
        .o_clk        (rxc),
        .o_data       (rxd),
        .o_frame      (rxf),
        .o_los        (rxl)
    );

    always #20 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        @(negedge i_clk_sys);
        v = rv_bus;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // waits for the chosen transmit clock edge and takes the launched bit
    task automatic tx_edge(input logic rise);
        logic prev;
        prev = txc;
        for (int n = 0; n < 100; n++) begin
            @(negedge i_clk_sys);
            if (txc === rise && prev === !rise) break;
            prev = txc;
        end
        d  = txd;
        fp = txf;
        c1 = cyc;
    endtask

    task automatic tx_period(input int exp);
        // first edge after a source change may be a short one
        tx_edge(1'b1);
        tx_edge(1'b1);
        c0 = c1;
        tx_edge(1'b1);
        chk_n(c1 - c0, exp);
    endtask

    task automatic run_tx(input logic [15:0] ctl, input logic rise);
        b = 8'($urandom);
        wr(`REG_CTRL, 16'h0000);
        wr(`REG_TX, {8'h00, b});
        wr(`REG_CTRL, ctl);
        for (int i = 7; i >= 0; i--) begin
            tx_edge(rise);
            chk({15'h0000, fp}, {15'h0000, i == 7});
            chk({15'h0000, d}, {15'h0000, b[i]});
        end
        $display("test tx ctrl %h done", ctl);
    endtask

    task automatic run_rx(input logic [15:0] ctl, input logic lr);
        b = 8'($urandom);
        @(posedge i_clk_sys);
        run <= 1'b0;
        idl_and_cfg(ctl, lr);
        rd(`REG_RX, rv);
        chk(rv, {6'h00, 1'b1, 1'b0, b});
        rd(`REG_STATUS, rv);
        chk(rv & 16'h0003, 16'h0003);
        $display("test rx ctrl %h done", ctl);
    endtask

    task automatic idl_and_cfg(input logic [15:0] ctl, input logic lr);
        idle(20);
        wr(`REG_CTRL, 16'h0000);
        wr(`REG_STATUS, 16'h001F);
        wr(`REG_CTRL, ctl);
        @(posedge i_clk_sys);
        pbyte <= b;
        lrise <= lr;
        run   <= 1'b1;
        idle(100);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        b = 8'($urandom(48856));
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), rv);
            chk(rv, 16'h0000);
        end
        chk({12'h000, irq, smode, txc, txd}, 16'h0000);
        @(posedge i_clk_sys);
        run <= 1'b1;
        k = 0;
        repeat (40) begin
            @(negedge i_clk_sys);
            if (txc !== 1'b0) k++;
        end
        chk_n(k, 0);
        $display("test serial off done");
        run_rx(16'h0001, 1'b0);
        run_rx(16'h0003, 1'b1);
        // restart the far end mid-frame while still locked
        @(posedge i_clk_sys);
        run <= 1'b0;
        idle(20);
        wr(`REG_STATUS, 16'h001F);
        @(posedge i_clk_sys);
        run <= 1'b1;
        idle(100);
        rd(`REG_STATUS, rv);
        chk(rv & 16'h0009, 16'h0009);
        $display("test misalign done");
        wr(`REG_MASK, 16'h0000);
        @(posedge i_clk_sys);
        los <= 1'b1;
        idle(10);
        chk({15'h0000, irq}, 16'h0000);
        rd(`REG_RX, rv);
        chk(rv & 16'h0300, 16'h0100);
        wr(`REG_MASK, 16'h0004);
        idle(2);
        chk({15'h0000, irq}, 16'h0001);
        @(posedge i_clk_sys);
        los <= 1'b0;
        idle(10);
        wr(`REG_STATUS, 16'h0004);
        idle(2);
        chk({15'h0000, irq}, 16'h0000);
        $display("test loss irq done");
        wr(`REG_CTRL, 16'h0009);
        rd(`REG_CTRL, rv);
        chk(rv, 16'h0009);
        chk({15'h0000, smode}, 16'h0001);
        tx_period(8);
        run_tx(16'h0001, 1'b1);
        tx_period(`LOCAL_CLK_NS / `SYS_CLK_NS);
        k = 0;
        do begin
            tx_edge(1'b1);
            k++;
        end while (fp !== 1'b1 && k < 7000);
        chk_n(k, `FRAME_BITS - 10);
        run_tx(16'h0005, 1'b0);
        close_out();
    end
endmodule
